// File: board_reset_sequencer_tb_top.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: short delay of 20 cycles
// Notes: inputs change at rising edges, outputs sampled at falling
module board_reset_sequencer_tb_top
  import brs_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ac_on = 1'b0;
  logic fp_n = 1'b1;
  logic [5:0] req = 6'h00;
  logic spg, mrst_n, pg, pci_n, init_n, busy;
  int failures = 0;
  int n_tests = 0;
  int n;
  // bit7 power good after request, bit6 panel press, rest request lines
  logic [7:0] rows [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h84, 8'h82, 8'h81};

  always #4 clk = ~clk;

  brs_sequencer #(.DELAY_CYCLES(DLY)) dut (.clk(clk), .reset(reset),
    .supply_power_good(spg), .front_panel_reset_n(fp_n), .io_hub_hard_req(req[5]),
    .debug_probe_reset_req(req[4]), .cpu_subsys_reset_req(req[3]),
    .super_io_kbd_reset_req(req[2]), .io_hub_soft_req(req[1]),
    .os_soft_reset_req(req[0]), .mgmt_ctrl_reset_n(mrst_n), .cpu_power_good(pg),
    .pci_reset_n(pci_n), .cpu_init_n(init_n), .seq_busy(busy));
  brs_supply_model #(.RAIL(4)) sup (.clk(clk), .ac_on(ac_on), .supply_power_good(spg));

  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // bounded wait for supply (sel=1) or processor power good
  task automatic wait_hi(input bit sel, input int lim);
    n = 0;
    while ((sel ? spg : pg) !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if ((sel ? spg : pg) !== 1'b1)
    begin
      failures++;
      summarize();
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(negedge clk);
    chk("mgmt_in_reset", mrst_n, 1'b0);
    chk("pg_in_reset", pg, 1'b0);
    @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(negedge clk);
    chk("mgmt_after", mrst_n, 1'b1);
  endtask

  initial
  begin
    do_reset();
    @(posedge clk);
    ac_on <= 1'b1;
    wait_hi(1'b1, 10);
    wait_hi(1'b0, 100);
    chk("pg_delay", n, DLY + 1);
    chk("busy_done", busy, 1'b0);
    chk("pci_held", pci_n, 1'b0);
    repeat (20) @(negedge clk);
    chk("pci_free", pci_n, 1'b1);
    // one request per row, released after a cycle
    foreach (rows[i])
    begin
      @(posedge clk);
      fp_n <= ~rows[i][6];
      req <= rows[i][5:0];
      @(posedge clk);
      fp_n <= 1'b1;
      req <= 6'h00;
      repeat (3) @(negedge clk);
      chk("row_pg", pg, rows[i][7]);
      chk("row_init", init_n, !rows[i][7]);
      chk("row_mgmt", mrst_n, 1'b1);
      wait_hi(1'b0, DLY + 4);
      if (!rows[i][7])
        chk("re_rise", n, DLY - 2);
      repeat (20) @(negedge clk);
      chk("row_pci", pci_n, 1'b1);
    end
    // second hard request mid-delay restarts the whole delay
    @(posedge clk);
    req <= 6'h10;
    @(posedge clk);
    req <= 6'h00;
    repeat (10) @(posedge clk);
    req <= 6'h20;
    @(posedge clk);
    req <= 6'h00;
    wait_hi(1'b0, DLY + 4);
    chk("re_restart", n, DLY + 1);
    // supply loss mid-delay, with a soft request that must be ignored
    @(posedge clk);
    ac_on <= 1'b0;
    repeat (4) @(negedge clk);
    chk("pg_lost", pg, 1'b0);
    @(posedge clk);
    ac_on <= 1'b1;
    wait_hi(1'b1, 10);
    repeat (10) @(negedge clk);
    chk("busy_wait", busy, 1'b1);
    @(posedge clk);
    ac_on <= 1'b0;
    req <= 6'h01;
    @(posedge clk);
    ac_on <= 1'b1;
    req <= 6'h00;
    repeat (3) @(negedge clk);
    chk("soft_refused", init_n, 1'b1);
    wait_hi(1'b1, 10);
    wait_hi(1'b0, 100);
    chk("restart_delay", n, DLY + 1);
    do_reset();
    chk("pg_after_rst", pg, 1'b0);
    summarize();
  end
endmodule

// File: brs_pkg.sv
// Purpose: constants shared by the board reset sequencer
// Assumes: 125 MHz clock, all inputs synchronous to clk
// Notes: the long delay count is overridable at the top module
package brs_pkg;
  localparam int unsigned BRS_CLK_HZ = 125000000;
  localparam int unsigned BRS_DELAY_MS = 500;
  localparam int unsigned BRS_DELAY_CYCLES = (BRS_CLK_HZ / 1000) * BRS_DELAY_MS;
  localparam int unsigned BRS_CNT_W = 27;
  localparam int unsigned BRS_PCI_PULSE_CYCLES = 16;
  localparam int unsigned BRS_SOFT_PULSE_CYCLES = 16;
  localparam int unsigned BRS_PULSE_W = 5;
  localparam logic BRS_PWRGD_RST = 1'b0;
  localparam logic BRS_RESET_N_RST = 1'b0;
  typedef enum logic [1:0] {BRS_OFF, BRS_WAIT, BRS_ON} brs_state_type;
endpackage

// File: brs_pulse.sv
// Purpose: fixed-length pulse generator, retriggerable
// Assumes: trigger is a one-cycle or level request
// Notes: output is a flop, high for LEN cycles after the last trigger
module brs_pulse
  import brs_pkg::*;
#(
  parameter logic [BRS_PULSE_W-1:0] LEN = 5'h10
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // request and pulse
  input wire logic trig,
  output logic pulse
);
  logic [BRS_PULSE_W-1:0] cnt_q;
  logic [BRS_PULSE_W-1:0] cnt_d;

  // reload on trigger, otherwise count down to zero
  assign cnt_d = trig ? LEN : ((cnt_q != 5'h00) ? cnt_q - 5'h01 : cnt_q);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q <= 5'h00;
      pulse <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      pulse <= (cnt_d != 5'h00);
    end
  end
endmodule

// File: brs_sequencer.sv
// Purpose: board reset sequencing for processors and I/O hub
// Assumes: single 125 MHz clock, inputs synchronous, reset is the standby-domain monitor
// Notes: management controller reset is only the standby monitor, never hard reset
module brs_sequencer
  import brs_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = BRS_DELAY_CYCLES
)
(
  // clock and standby power-on reset
  input wire logic clk,
  input wire logic reset,
  // supply status
  input wire logic supply_power_good,
  // hard reset sources
  input wire logic front_panel_reset_n,
  input wire logic io_hub_hard_req,
  input wire logic debug_probe_reset_req,
  input wire logic cpu_subsys_reset_req,
  // soft reset sources
  input wire logic super_io_kbd_reset_req,
  input wire logic io_hub_soft_req,
  input wire logic os_soft_reset_req,
  // outputs
  output logic mgmt_ctrl_reset_n,
  output logic cpu_power_good,
  output logic pci_reset_n,
  output logic cpu_init_n,
  output logic seq_busy
);
  localparam logic [BRS_CNT_W-1:0] DLY_LAST = BRS_CNT_W'(DELAY_CYCLES - 1);
  localparam logic [BRS_PULSE_W-1:0] PCI_LEN = BRS_PULSE_W'(BRS_PCI_PULSE_CYCLES);
  localparam logic [BRS_PULSE_W-1:0] SOFT_LEN = BRS_PULSE_W'(BRS_SOFT_PULSE_CYCLES);

  brs_state_type state_q;
  brs_state_type state_d;
  logic [BRS_CNT_W-1:0] cnt_q;
  logic [BRS_CNT_W-1:0] cnt_d;
  logic fp_q;
  logic pg_prev_q;
  logic pci_pulse;
  logic soft_pulse;

  // hard reset sources; front panel taken on its press edge only
  wire fp_press = fp_q & ~front_panel_reset_n;
  wire hard_req = fp_press | io_hub_hard_req | debug_probe_reset_req
                  | cpu_subsys_reset_req;
  // soft sources only pulse init; power-good is untouched
  wire soft_req = super_io_kbd_reset_req | io_hub_soft_req
                  | os_soft_reset_req;
  wire dly_done = (cnt_q == DLY_LAST);
  wire pg_rise = (state_d == BRS_ON) & (state_q != BRS_ON);

  // sequencing: supply loss always wins, restarting the delay
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      BRS_OFF:
      begin
        cnt_d = '0;
        if (supply_power_good)
          state_d = BRS_WAIT;
      end
      BRS_WAIT:
      begin
        cnt_d = cnt_q + 1'b1;
        if (!supply_power_good)
          state_d = BRS_OFF;
        else if (hard_req)
          cnt_d = '0;
        else if (dly_done)
          state_d = BRS_ON;
      end
      BRS_ON:
      begin
        cnt_d = '0;
        if (!supply_power_good)
          state_d = BRS_OFF;
        else if (hard_req)
          state_d = BRS_WAIT;
      end
    endcase
  end

  // state, counter and registered outputs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= BRS_OFF;
      cnt_q <= '0;
      fp_q <= 1'b1;
      pg_prev_q <= BRS_PWRGD_RST;
      cpu_power_good <= BRS_PWRGD_RST;
      seq_busy <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      fp_q <= front_panel_reset_n;
      pg_prev_q <= cpu_power_good;
      cpu_power_good <= (state_d == BRS_ON);
      seq_busy <= (state_d == BRS_WAIT);
    end
  end

  // controller reset only from the standby monitor, never from hard reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      mgmt_ctrl_reset_n <= BRS_RESET_N_RST;
    else
      mgmt_ctrl_reset_n <= 1'b1;
  end

  // pci reset pulse at each power-good assertion
  brs_pulse #(.LEN(PCI_LEN)) u_pci
  (
    .clk(clk),
    .reset(reset),
    .trig(pg_rise),
    .pulse(pci_pulse)
  );

  // soft reset pulse, only while power is stable
  brs_pulse #(.LEN(SOFT_LEN)) u_soft
  (
    .clk(clk),
    .reset(reset),
    .trig(soft_req & (state_q == BRS_ON)),
    .pulse(soft_pulse)
  );

  // outputs inverted from pulse flops through one more flop
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pci_reset_n <= 1'b0;
      cpu_init_n <= 1'b1;
    end
    else
    begin
      pci_reset_n <= ~pci_pulse & cpu_power_good;
      cpu_init_n <= ~soft_pulse;
    end
  end

  property p_pg_needs_supply;
    @(posedge clk) disable iff (reset)
    cpu_power_good |-> $past(supply_power_good);
  endproperty
  a_pg_needs_supply: assert property (p_pg_needs_supply)
    else $error("cpu power good without supply power good");

  property p_pg_after_delay;
    @(posedge clk) disable iff (reset)
    $rose(cpu_power_good) |-> $past(dly_done);
  endproperty
  a_pg_after_delay: assert property (p_pg_after_delay)
    else $error("cpu power good rose before delay finished");

  property p_hard_drops_pg;
    @(posedge clk) disable iff (reset)
    (state_q == BRS_ON && supply_power_good && hard_req) |=> !cpu_power_good;
  endproperty
  a_hard_drops_pg: assert property (p_hard_drops_pg)
    else $error("hard reset did not drop cpu power good");

  property p_hard_restarts;
    @(posedge clk) disable iff (reset)
    (state_q == BRS_ON && supply_power_good && hard_req) |=> state_q == BRS_WAIT && cnt_q == '0;
  endproperty
  a_hard_restarts: assert property (p_hard_restarts)
    else $error("hard reset did not restart the delay");

  property p_supply_loss;
    @(posedge clk) disable iff (reset)
    !supply_power_good |=> state_q == BRS_OFF ##1 !cpu_power_good;
  endproperty
  a_supply_loss: assert property (p_supply_loss)
    else $error("supply loss did not abort the sequence");

  property p_mgmt_runs;
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> mgmt_ctrl_reset_n;
  endproperty
  a_mgmt_runs: assert property (p_mgmt_runs)
    else $error("controller reset outside standby reset");

  property p_pci_pulse;
    @(posedge clk) disable iff (reset)
    $rose(cpu_power_good) |=> !pci_reset_n [*8];
  endproperty
  a_pci_pulse: assert property (p_pci_pulse)
    else $error("pci reset not pulsed at power good");

  property p_soft_keeps_pg;
    @(posedge clk) disable iff (reset)
    (soft_req && state_q == BRS_ON && !hard_req && supply_power_good)
      |=> cpu_power_good ##1 !cpu_init_n;
  endproperty
  a_soft_keeps_pg: assert property (p_soft_keeps_pg)
    else $error("soft reset misbehaved");

  property p_src_taken;
    @(posedge clk) disable iff (reset)
    (state_q == BRS_ON && supply_power_good && (debug_probe_reset_req || cpu_subsys_reset_req))
      |=> state_q == BRS_WAIT;
  endproperty
  a_src_taken: assert property (p_src_taken)
    else $error("reset source ignored");

  c_pg_up: cover property (@(posedge clk) disable iff (reset) $rose(cpu_power_good));
  c_hard: cover property (@(posedge clk) disable iff (reset) state_q == BRS_ON && fp_press);
  c_soft: cover property (@(posedge clk) disable iff (reset) $fell(cpu_init_n));
  c_abort: cover property (@(posedge clk) disable iff (reset)
    state_q == BRS_WAIT && !supply_power_good);
endmodule

// File: brs_supply_model.sv
// Purpose: supply model facing the reset sequencer
// Assumes: ac_on driven by the bench
// Notes: rails settle RAIL cycles before power good
module brs_supply_model
#(
  parameter int RAIL = 4
)
(
  // clock
  input wire logic clk,
  // mains in, status out
  input wire logic ac_on,
  output logic supply_power_good = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  // good only once every rail has settled, lost at once with mains
  always @(posedge clk)
  begin
    n <= ac_on ? ((n < RAIL) ? n + 1 : n) : 0;
    supply_power_good <= ac_on && (n == RAIL);
  end
endmodule
